// *** rtl/fns_status.sv ***
// node status reporting core: obstacle and detection-disable bitmaps,
// link scan statistics, slave function state, error word, i/o address map
// assumes network-side inputs are driven by logic on pclk
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - 64 obstacle bits in four words; bit n of word k is node 16k+n.
// - a message read of a node's error information clears its obstacle bit.
// - detection-disable bits: 0 lets a down node raise the down flag, 1 hides it.
// - latest link scan time is reported in milliseconds.
// - smallest link scan time since power-on is reported in milliseconds.
// - largest link scan time since power-on is reported in milliseconds.
// - state codes: 00 offline, 40 stopped, 80 waiting, c0 operating.
// - offline is shown while initialising, after bus-off, or without network power.
// - manual start: offline to stop; request flag gives waiting, master request operate.
// - auto start heads for operate but shows stop until the master requests i/o.
// - a network reset message drops to offline, then the path is walked again.
// - error word: code in high byte, node in low byte; fe or ff is local.
// - i/o map holds four words per node, 252 words by default.
module fns_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic obst_set_valid,
    input wire logic [5:0] obst_set_node,
    input wire logic msg_err_read,
    input wire logic [5:0] msg_err_node,
    input wire logic [63:0] node_down_vec,
    input wire logic scan_done,
    input wire logic [15:0] scan_time_ms,
    input wire logic net_init_busy,
    input wire logic bus_off,
    input wire logic net_power_ok,
    input wire logic master_io_req,
    input wire logic reset_msg,
    input wire logic err_valid,
    input wire logic [7:0] err_code,
    input wire logic [7:0] err_node,
    input wire logic map_wr,
    input wire logic [7:0] map_waddr,
    input wire logic [15:0] map_wdata,
    output logic slave_down_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic wr_acc;
    logic sel_ctrl, sel_status, sel_err, sel_cur, sel_min, sel_max, sel_mlen;
    logic sel_obst, sel_ddis, sel_istat, sel_iclr, sel_ien, sel_map, hit;
    logic [1:0] word_idx;
    logic [7:0] map_idx;

    assign wr_acc = psel & penable & pwrite;
    assign sel_ctrl = (paddr == fns_pkg::OFF_CTRL);
    assign sel_status = (paddr == fns_pkg::OFF_STATUS);
    assign sel_err = (paddr == fns_pkg::OFF_ERR);
    assign sel_cur = (paddr == fns_pkg::OFF_SCAN_CUR);
    assign sel_min = (paddr == fns_pkg::OFF_SCAN_MIN);
    assign sel_max = (paddr == fns_pkg::OFF_SCAN_MAX);
    assign sel_mlen = (paddr == fns_pkg::OFF_MAP_LEN);
    assign sel_obst = (paddr[11:4] == fns_pkg::OFF_OBST0[11:4]) && (paddr[1:0] == 2'h0);
    assign sel_ddis = (paddr[11:4] == fns_pkg::OFF_DDIS0[11:4]) && (paddr[1:0] == 2'h0);
    assign sel_istat = (paddr == fns_pkg::OFF_IRQ_STAT);
    assign sel_iclr = (paddr == fns_pkg::OFF_IRQ_CLR);
    assign sel_ien = (paddr == fns_pkg::OFF_IRQ_EN);
    assign word_idx = paddr[3:2];
    assign map_idx = paddr[9:2];
    assign sel_map = (paddr[11:10] == fns_pkg::OFF_MAP_BASE[11:10])
        && (paddr[1:0] == 2'h0) && (int'(map_idx) < fns_pkg::MAP_DEPTH);
    assign hit = sel_ctrl | sel_status | sel_err | sel_cur | sel_min | sel_max
        | sel_mlen | sel_obst | sel_ddis | sel_istat | sel_iclr | sel_ien | sel_map;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    logic auto_start_q;
    logic io_comm_request_flag_q;
    logic [2:0] obst_len_q;
    logic [2:0] ddis_len_q;
    logic [7:0] map_len_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_start_q <= 1'b0;
            io_comm_request_flag_q <= 1'b0;
            obst_len_q <= fns_pkg::OBST_LEN_RST;
            ddis_len_q <= fns_pkg::DDIS_LEN_RST;
        end else if (wr_acc && sel_ctrl) begin
            auto_start_q <= pwdata[fns_pkg::CTRL_AUTO_BIT];
            io_comm_request_flag_q <= pwdata[fns_pkg::CTRL_REQ_BIT];
            obst_len_q <= pwdata[fns_pkg::CTRL_OLEN_LSB +: 3];
            ddis_len_q <= pwdata[fns_pkg::CTRL_DLEN_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            map_len_q <= fns_pkg::MAP_LEN_RST;
        end else if (wr_acc && sel_mlen) begin
            map_len_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // obstacle bitmap, one bit per node
    logic [63:0] obst_q;

    for (genvar n = 0; n < fns_pkg::NODES; n++) begin : g_obst
        logic set_n, clr_n;
        assign set_n = obst_set_valid && (obst_set_node == 6'(n));
        assign clr_n = msg_err_read && (msg_err_node == 6'(n));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                obst_q[n] <= 1'b0;
            end else if (set_n) begin
                obst_q[n] <= 1'b1;
            end else if (clr_n) begin
                obst_q[n] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // detection-disable bitmap and down flag
    logic [63:0] ddis_q;
    logic [63:0] ddis_wmask;

    assign ddis_wmask = 64'hffff << {word_idx, 4'h0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ddis_q <= '0;
        end else if (wr_acc && sel_ddis) begin
            ddis_q <= (ddis_q & ~ddis_wmask) | ({48'h0, pwdata[15:0]} << {word_idx, 4'h0});
        end
    end

    logic down_d;

    assign down_d = |(node_down_vec & ~ddis_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_down_flag <= 1'b0;
        end else begin
            slave_down_flag <= down_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link scan statistics
    logic [15:0] scan_cur_q, scan_min_q, scan_max_q;
    logic scan_seen_q;
    logic new_min, new_max;

    assign new_min = !scan_seen_q || (scan_time_ms < scan_min_q);
    assign new_max = !scan_seen_q || (scan_time_ms > scan_max_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cur_q <= '0;
            scan_min_q <= '0;
            scan_max_q <= '0;
            scan_seen_q <= 1'b0;
        end else if (scan_done) begin
            scan_cur_q <= scan_time_ms;
            scan_seen_q <= 1'b1;
            if (new_min) begin
                scan_min_q <= scan_time_ms;
            end
            if (new_max) begin
                scan_max_q <= scan_time_ms;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slave function state machine
    fns_pkg::fns_state_t state_q, state_d;
    logic offline_cond;
    logic [7:0] state_code;

    assign offline_cond = net_init_busy | bus_off | ~net_power_ok | reset_msg;

    always_comb begin
        state_d = state_q;
        if (offline_cond) begin
            state_d = fns_pkg::ST_OFFLINE;
        end else begin
            unique case (state_q)
                fns_pkg::ST_OFFLINE: begin
                    state_d = fns_pkg::ST_STOP;
                end
                fns_pkg::ST_STOP: begin
                    if (auto_start_q && master_io_req) begin
                        state_d = fns_pkg::ST_OPERATE;
                    end else if (!auto_start_q && io_comm_request_flag_q) begin
                        state_d = fns_pkg::ST_READY;
                    end
                end
                fns_pkg::ST_READY: begin
                    if (auto_start_q || !io_comm_request_flag_q) begin
                        state_d = fns_pkg::ST_STOP;
                    end else if (master_io_req) begin
                        state_d = fns_pkg::ST_OPERATE;
                    end
                end
                fns_pkg::ST_OPERATE: begin
                    if (!auto_start_q && !io_comm_request_flag_q) begin
                        state_d = fns_pkg::ST_STOP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fns_pkg::ST_OFFLINE;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        unique case (state_q)
            fns_pkg::ST_OFFLINE: state_code = fns_pkg::CODE_OFFLINE;
            fns_pkg::ST_STOP: state_code = fns_pkg::CODE_STOP;
            fns_pkg::ST_READY: state_code = fns_pkg::CODE_READY;
            fns_pkg::ST_OPERATE: state_code = fns_pkg::CODE_OPERATE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // error word
    logic [15:0] err_info_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_info_q <= '0;
        end else if (err_valid) begin
            err_info_q <= {err_code, err_node};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts
    logic [4:0] irq_stat_q, irq_en_q, irq_set, irq_clr;
    logic down_rise;

    assign down_rise = down_d & ~slave_down_flag;
    assign irq_set = {state_d != state_q, err_valid, scan_done, down_rise, obst_set_valid};
    assign irq_clr = (wr_acc && sel_iclr) ? pwdata[4:0] : 5'h0;
    assign irq = |(irq_stat_q & irq_en_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= '0;
        end else if (wr_acc && sel_ien) begin
            irq_en_q <= pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // i/o address map and read mux
    logic [15:0] map_rdata;

    fns_map_ram #(
        .DEPTH(fns_pkg::MAP_DEPTH),
        .AW(fns_pkg::MAP_AW),
        .DW(fns_pkg::MAP_DW)
    ) u_map (
        .pclk(pclk),
        .wr_en(map_wr),
        .wr_addr(map_waddr),
        .wr_data(map_wdata),
        .rd_addr(map_idx),
        .rd_data(map_rdata)
    );

    logic [15:0] obst_word, ddis_word;
    logic obst_in_len, ddis_in_len, map_in_len;

    assign obst_word = obst_q[{word_idx, 4'h0} +: 16];
    assign ddis_word = ddis_q[{word_idx, 4'h0} +: 16];
    assign obst_in_len = {1'b0, word_idx} < obst_len_q;
    assign ddis_in_len = {1'b0, word_idx} < ddis_len_q;
    assign map_in_len = map_idx < map_len_q;

    always_comb begin
        prdata = 32'h0;
        if (sel_ctrl) begin
            prdata = {24'h0, ddis_len_q, obst_len_q, io_comm_request_flag_q, auto_start_q};
        end else if (sel_status) begin
            prdata = {23'h0, slave_down_flag, state_code};
        end else if (sel_err) begin
            prdata = {16'h0, err_info_q};
        end else if (sel_cur) begin
            prdata = {16'h0, scan_cur_q};
        end else if (sel_min) begin
            prdata = {16'h0, scan_min_q};
        end else if (sel_max) begin
            prdata = {16'h0, scan_max_q};
        end else if (sel_mlen) begin
            prdata = {24'h0, map_len_q};
        end else if (sel_obst && obst_in_len) begin
            prdata = {16'h0, obst_word};
        end else if (sel_ddis && ddis_in_len) begin
            prdata = {16'h0, ddis_word};
        end else if (sel_istat) begin
            prdata = {27'h0, irq_stat_q};
        end else if (sel_ien) begin
            prdata = {27'h0, irq_en_q};
        end else if (sel_map && map_in_len) begin
            prdata = {16'h0, map_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_obst_set: assert property (
        obst_set_valid |=> obst_q[$past(obst_set_node)])
        else $error("obstacle bit not set for reported node");

    chk_obst_clear: assert property (
        msg_err_read && !(obst_set_valid && obst_set_node == msg_err_node)
        |=> !obst_q[$past(msg_err_node)])
        else $error("obstacle bit not cleared by error read");

    chk_down_mask: assert property (
        ##1 slave_down_flag == |($past(node_down_vec) & $past(~ddis_q)))
        else $error("down flag disagrees with disable map");

    chk_scan_cur: assert property (
        scan_done |=> scan_cur_q == $past(scan_time_ms))
        else $error("present scan time not captured");

    chk_scan_min: assert property (
        scan_done && scan_seen_q |=> scan_min_q <= $past(scan_time_ms)
        && scan_min_q <= $past(scan_min_q))
        else $error("scan minimum wrong");

    chk_scan_max: assert property (
        scan_done && scan_seen_q |=> scan_max_q >= $past(scan_time_ms)
        && scan_max_q >= $past(scan_max_q))
        else $error("scan maximum wrong");

    chk_state_code: assert property (
        state_q == fns_pkg::ST_READY |-> prdata[7:0] == 8'h80 || !sel_status)
        else $error("waiting state code wrong");

    chk_offline_hold: assert property (
        (bus_off || !net_power_ok) |=> state_q == fns_pkg::ST_OFFLINE)
        else $error("not offline on bus-off or power loss");

    chk_manual_ready: assert property (
        state_q == fns_pkg::ST_STOP && !auto_start_q && io_comm_request_flag_q
        && !offline_cond |=> state_q == fns_pkg::ST_READY ##1
        (state_q != fns_pkg::ST_OPERATE || $past(master_io_req)))
        else $error("manual start path wrong");

    chk_auto_stop: assert property (
        state_q == fns_pkg::ST_STOP && auto_start_q && !master_io_req
        && !offline_cond |=> state_q == fns_pkg::ST_STOP)
        else $error("auto start left stop without master request");

    chk_reset_msg: assert property (
        reset_msg ##1 !offline_cond |=> state_q == fns_pkg::ST_STOP)
        else $error("reset message did not restart from offline");

    chk_err_word: assert property (
        err_valid |=> err_info_q == {$past(err_code), $past(err_node)})
        else $error("error word not captured");

endmodule

// *** rtl/fns_pkg.sv ***
// shared constants of the fieldbus node status block
// assumes a 32-bit apb slave with 12-bit byte addresses
package fns_pkg;

    localparam int ADDR_W = 12;
    localparam int LEN_W = 3;
    localparam int MAP_AW = 8;
    localparam int MAP_DW = 16;
    localparam int NODES = 64;
    localparam int IRQ_W = 5;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ERR = 12'h008;
    localparam logic [11:0] OFF_SCAN_CUR = 12'h00c;
    localparam logic [11:0] OFF_SCAN_MIN = 12'h010;
    localparam logic [11:0] OFF_SCAN_MAX = 12'h014;
    localparam logic [11:0] OFF_MAP_LEN = 12'h018;
    localparam logic [11:0] OFF_OBST0 = 12'h020;
    localparam logic [11:0] OFF_DDIS0 = 12'h030;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h040;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h044;
    localparam logic [11:0] OFF_IRQ_EN = 12'h048;
    localparam logic [11:0] OFF_MAP_BASE = 12'h400;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_REQ_BIT = 1;
    localparam int CTRL_OLEN_LSB = 2;
    localparam int CTRL_DLEN_LSB = 5;
    localparam int STAT_DOWN_BIT = 8;
    localparam int IRQ_OBST = 0;
    localparam int IRQ_DOWN = 1;
    localparam int IRQ_SCAN = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_STATE = 4;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset, and map depth
    localparam logic [2:0] OBST_LEN_RST = 3'h4;
    localparam logic [2:0] DDIS_LEN_RST = 3'h4;
    localparam logic [7:0] MAP_LEN_RST = 8'hfc;
    localparam int MAP_DEPTH = 252;

    ////////////////////////////////////////////////////////////////////////////
    // slave function state codes
    localparam logic [7:0] CODE_OFFLINE = 8'h00;
    localparam logic [7:0] CODE_STOP = 8'h40;
    localparam logic [7:0] CODE_READY = 8'h80;
    localparam logic [7:0] CODE_OPERATE = 8'hc0;

    typedef enum logic [1:0] {
        ST_OFFLINE = 2'h0,
        ST_STOP = 2'h1,
        ST_READY = 2'h3,
        ST_OPERATE = 2'h2
    } fns_state_t;

endpackage

// *** rtl/fns_map_ram.sv ***
// node i/o address map storage, one write port and one registered read port
// assumes writer and reader share pclk
`timescale 1ns/100ps
module fns_map_ram #(
    parameter int DEPTH = 252,
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk) begin
        if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end

endmodule

// *** test/fns_net_model.sv ***
// network-side model: fieldbus master and remote slave nodes
// assumes tasks are called from the bench; drives on pclk rising edges
`timescale 1ns/100ps
module fns_net_model (
    input wire logic pclk,
    output logic obst_set_valid,
    output logic [5:0] obst_set_node,
    output logic msg_err_read,
    output logic [5:0] msg_err_node,
    output logic [63:0] node_down_vec,
    output logic scan_done,
    output logic [15:0] scan_time_ms,
    output logic net_init_busy,
    output logic bus_off,
    output logic net_power_ok,
    output logic master_io_req,
    output logic reset_msg,
    output logic err_valid,
    output logic [7:0] err_code,
    output logic [7:0] err_node,
    output logic map_wr,
    output logic [7:0] map_waddr,
    output logic [15:0] map_wdata
);
    initial begin
        {obst_set_valid, msg_err_read, scan_done, reset_msg, err_valid, map_wr} = '0;
        {net_init_busy, bus_off, master_io_req, node_down_vec} = '0;
        net_power_ok = 1'b1;
        {obst_set_node, msg_err_node, scan_time_ms, err_code, err_node} = '0;
        {map_waddr, map_wdata} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // event pulses and held input levels; pulse data lines inverted once released
    task automatic obst(input logic set, input logic [5:0] n);
        @(posedge pclk);
        obst_set_valid <= set;
        msg_err_read <= ~set;
        {obst_set_node, msg_err_node} <= {n, n};
        @(posedge pclk);
        {obst_set_valid, msg_err_read} <= 2'h0;
        {obst_set_node, msg_err_node} <= ~{n, n};
    endtask

    task automatic scan(input logic [15:0] t);
        @(posedge pclk);
        scan_done <= 1'b1;
        scan_time_ms <= t;
        @(posedge pclk);
        scan_done <= 1'b0;
        scan_time_ms <= ~t;
    endtask

    task automatic err(input logic [7:0] c, input logic [7:0] n);
        @(posedge pclk);
        err_valid <= 1'b1;
        {err_code, err_node} <= {c, n};
        @(posedge pclk);
        err_valid <= 1'b0;
        {err_code, err_node} <= ~{c, n};
    endtask

    task automatic map(input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        map_wr <= 1'b1;
        {map_waddr, map_wdata} <= {a, d};
        @(posedge pclk);
        map_wr <= 1'b0;
        {map_waddr, map_wdata} <= ~{a, d};
    endtask

    task automatic net_reset();
        @(posedge pclk);
        reset_msg <= 1'b1;
        @(posedge pclk);
        reset_msg <= 1'b0;
    endtask

    task automatic levels(input logic [2:0] off, input logic req, input logic [63:0] dn);
        @(posedge pclk);
        {net_init_busy, bus_off} <= off[1:0];
        net_power_ok <= ~off[2];
        master_io_req <= req;
        node_down_vec <= dn;
    endtask
endmodule

// *** test/test_fieldbus_node_status_reporting.sv ***
// self-checking bench of the node status block over apb
// assumes fns_pkg and the network model are compiled first
`timescale 1ns/100ps
`define CHK(g, e) check(32'(g), 32'(e))
module test_fieldbus_node_status_reporting;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, rerr, slave_down_flag, irq;
    logic obst_set_valid, msg_err_read, scan_done, net_init_busy, bus_off, net_power_ok;
    logic master_io_req, reset_msg, err_valid, map_wr;
    logic [5:0] obst_set_node, msg_err_node;
    logic [63:0] node_down_vec;
    logic [15:0] scan_time_ms, map_wdata;
    logic [7:0] err_code, err_node, map_waddr;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    fns_status fns_status_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .obst_set_valid, .obst_set_node, .msg_err_read,
        .msg_err_node, .node_down_vec, .scan_done, .scan_time_ms, .net_init_busy, .bus_off,
        .net_power_ok, .master_io_req, .reset_msg, .err_valid, .err_code, .err_node,
        .map_wr, .map_waddr, .map_wdata, .slave_down_flag, .irq);
    fns_net_model fns_net_model_inst (.pclk, .obst_set_valid, .obst_set_node, .msg_err_read,
        .msg_err_node, .node_down_vec, .scan_done, .scan_time_ms, .net_init_busy, .bus_off,
        .net_power_ok, .master_io_req, .reset_msg, .err_valid, .err_code, .err_node,
        .map_wr, .map_waddr, .map_wdata);

    always #20 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    // compare, apb transfer, verdict
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdv, e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic pin(input logic dn, input logic e);
        @(posedge pclk);
        @(negedge pclk);
        `CHK(dn ? slave_down_flag : irq, e);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(fns_pkg::OFF_CTRL, 32'h90);
        rd(fns_pkg::OFF_MAP_LEN, 32'hfc);
        rd(fns_pkg::OFF_SCAN_MIN, 32'h0);
        rd(fns_pkg::OFF_SCAN_MAX, 32'h0);
        rd(fns_pkg::OFF_STATUS, 32'h40);
        wr(fns_pkg::OFF_CTRL, 32'h92);
        rd(fns_pkg::OFF_STATUS, 32'h80);
        fns_net_model_inst.levels(3'h0, 1'b1, 64'h0);
        rd(fns_pkg::OFF_STATUS, 32'hc0);
        wr(fns_pkg::OFF_IRQ_CLR, 32'h1f);
        fns_net_model_inst.net_reset();
        repeat (3) @(posedge pclk);
        rd(fns_pkg::OFF_STATUS, 32'hc0);
        rd(fns_pkg::OFF_IRQ_STAT, 32'h10);
        for (int i = 0; i < 3; i++) begin
            fns_net_model_inst.levels(3'(1 << i), 1'b1, 64'h0);
            rd(fns_pkg::OFF_STATUS, 32'h00);
            fns_net_model_inst.levels(3'h0, 1'b1, 64'h0);
            repeat (3) @(posedge pclk);
            rd(fns_pkg::OFF_STATUS, 32'hc0);
        end
        fns_net_model_inst.levels(3'h0, 1'b0, 64'h0);
        wr(fns_pkg::OFF_CTRL, 32'h91);
        fns_net_model_inst.net_reset();
        repeat (3) @(posedge pclk);
        rd(fns_pkg::OFF_STATUS, 32'h40);
        fns_net_model_inst.levels(3'h0, 1'b1, 64'h0);
        rd(fns_pkg::OFF_STATUS, 32'hc0);
        $display("state test done");

        wr(fns_pkg::OFF_IRQ_CLR, 32'h1f);
        wr(fns_pkg::OFF_IRQ_EN, 32'h01);
        fns_net_model_inst.obst(1'b1, 6'd0);
        fns_net_model_inst.obst(1'b1, 6'd15);
        fns_net_model_inst.obst(1'b1, 6'd16);
        fns_net_model_inst.obst(1'b1, 6'd63);
        pin(1'b0, 1'b1);
        fns_net_model_inst.obst(1'b0, 6'd15);
        rd(fns_pkg::OFF_OBST0, 32'h0001);
        rd(fns_pkg::OFF_OBST0 + 12'h4, 32'h0001);
        rd(fns_pkg::OFF_OBST0 + 12'h8, 32'h0000);
        rd(fns_pkg::OFF_OBST0 + 12'hc, 32'h8000);
        wr(fns_pkg::OFF_CTRL, 32'h84);
        rd(fns_pkg::OFF_OBST0 + 12'h4, 32'h0);
        wr(fns_pkg::OFF_IRQ_CLR, 32'h01);
        pin(1'b0, 1'b0);
        $display("obstacle test done");

        fns_net_model_inst.levels(3'h0, 1'b1, 64'h0010_0000);
        wr(fns_pkg::OFF_DDIS0 + 12'h4, 32'h0010);
        pin(1'b1, 1'b0);
        wr(fns_pkg::OFF_DDIS0 + 12'h4, 32'h0000);
        pin(1'b1, 1'b1);
        wr(fns_pkg::OFF_CTRL, 32'h30);
        wr(fns_pkg::OFF_DDIS0 + 12'h4, 32'h0010);
        rd(fns_pkg::OFF_DDIS0 + 12'h4, 32'h0);
        pin(1'b1, 1'b0);
        $display("down flag test done");

        wr(fns_pkg::OFF_IRQ_EN, 32'h04);
        fns_net_model_inst.scan(16'd10);
        fns_net_model_inst.scan(16'd5);
        fns_net_model_inst.scan(16'd20);
        pin(1'b0, 1'b1);
        rd(fns_pkg::OFF_SCAN_CUR, 32'd20);
        rd(fns_pkg::OFF_SCAN_MIN, 32'd5);
        rd(fns_pkg::OFF_SCAN_MAX, 32'd20);
        wr(fns_pkg::OFF_IRQ_EN, 32'h00);
        pin(1'b0, 1'b0);
        fns_net_model_inst.err(8'h5a, 8'hfe);
        rd(fns_pkg::OFF_ERR, 32'h5afe);
        fns_net_model_inst.err(8'h12, 8'h3f);
        rd(fns_pkg::OFF_ERR, 32'h123f);
        $display("scan and error test done");

        fns_net_model_inst.map(8'd0, 16'h1234);
        fns_net_model_inst.map(8'd251, 16'hbeef);
        rd(fns_pkg::OFF_MAP_BASE, 32'h1234);
        rd(fns_pkg::OFF_MAP_BASE + 12'h3ec, 32'hbeef);
        wr(fns_pkg::OFF_MAP_LEN, 32'h4);
        rd(fns_pkg::OFF_MAP_BASE + 12'h3ec, 32'h0);
        rd(12'h01c, 32'h0);
        `CHK(rerr, 1'b1);
        $display("map and bus test done");
        conclude();
    end
endmodule
